/* File: hall_readout_pkg.sv */
package hall_readout_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_KHZ = 40000;
   localparam int FIRST_HOLD_NS = 10;
   localparam int TRACK2_US = 32;
   localparam int HOLD2_US = 96;
   localparam int FIRST_HOLD_RAW = (FIRST_HOLD_NS * CLK_KHZ + 999999) / 1000000;
   localparam int FIRST_HOLD_CYC = (FIRST_HOLD_RAW < 1) ? 1 : FIRST_HOLD_RAW;
   localparam int TRACK2_CYC = TRACK2_US * CLK_KHZ / 1000;
   localparam int HOLD2_CYC = HOLD2_US * CLK_KHZ / 1000;
   localparam logic [11:0] TRACK2_CNT = 12'(TRACK2_CYC);
   localparam logic [11:0] HOLD2_CNT = 12'(HOLD2_CYC);

   // ----------------------------------------
   // Data formats
   // ----------------------------------------
   localparam int WORD_W = 12;
   localparam int FRAC_W = 7;
   localparam int ACC_W = WORD_W + FRAC_W;
   localparam logic [11:0] CODE_MID = 12'h800;
   localparam logic [11:0] CODE_MAX = 12'hfff;
   localparam logic [7:0] GAIN_BASE = 8'h60;

   // ----------------------------------------
   // Write command layout, first bit at 15
   // ----------------------------------------
   localparam int CMD_BITS = 16;
   localparam logic [4:0] CMD_LEN = 5'h10;
   localparam logic [4:0] CMD_CAP = 5'h11;
   localparam logic [1:0] CMD_LEAD = 2'h2;
   localparam int CMD_LEAD_POS = 14;
   localparam int CMD_WEIGHT_POS = 11;
   localparam int CMD_TRIM_POS = 5;
   localparam int CMD_PAD_POS = 1;
   localparam int CMD_BURN_POS = 0;
   localparam logic [3:0] CMD_PAD = 4'h0;
   localparam int OTP_W = 9;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_TRACK1 = 4'b0010,
      S_TRACK2 = 4'b0100,
      S_CONVERT = 4'b1000
   } acq_e;

   typedef struct packed {
      logic [2:0] sel_sync;
      logic [2:0] sck_sync;
      logic [1:0] din_sync;
      acq_e fsm;
      logic [11:0] cnt;
      logic conv_start;
      logic [11:0] shift;
      logic [15:0] cmd;
      logic [4:0] nbits;
      logic booted;
      logic [2:0] weight;
      logic [5:0] trim;
      logic burn_armed;
      logic [8:0] burn_val;
      logic burn_pulse;
      logic [8:0] burn_data;
      logic [18:0] acc;
      logic [11:0] code;
      logic pending;
   } top_s;

   typedef struct packed {
      logic [1:0] count;
      logic [11:0] word0;
      logic [11:0] word1;
   } buf_s;

endpackage

/* File: word_buf_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface word_buf_if;
   logic [11:0] wr_data;
   logic wr_valid;
   logic wr_ready;
   logic [11:0] rd_data;
   logic rd_valid;
   logic rd_ready;
   modport store (input wr_data, input wr_valid, output wr_ready,
                  output rd_data, output rd_valid, input rd_ready);
   modport user (output wr_data, output wr_valid, input wr_ready,
                 input rd_data, input rd_valid, output rd_ready);
endinterface
`default_nettype wire

/* File: word_buf.sv */
`timescale 1ns/10ps
`default_nettype none
module word_buf
(
   input wire logic sys_clk,
   input wire logic rst_b,
   word_buf_if.store bus
);
   import hall_readout_pkg::*;

   buf_s st;
   buf_s next_st;

   // ----------------------------------------
   // Two-entry queue, head always in word0
   // ----------------------------------------
   assign bus.wr_ready = (st.count != 2'h2);
   assign bus.rd_valid = (st.count != 2'h0);
   assign bus.rd_data = st.word0;

   always_comb
   begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      next_st = st;
      push = bus.wr_valid && bus.wr_ready;
      pop = bus.rd_valid && bus.rd_ready;
      if (pop)
      begin
         next_st.word0 = st.word1;
      end
      if (push)
      begin
         if (st.count == 2'h0 || (st.count == 2'h1 && pop))
         begin
            next_st.word0 = bus.wr_data;
         end
         else
         begin
            next_st.word1 = bus.wr_data;
         end
      end
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   chk_buf_never_over: assert property (@(posedge sys_clk) disable iff (!rst_b)
      st.count != 2'h3) else $error("buffer count out of range");

endmodule
`default_nettype wire

/* File: hall_readout.sv */
`timescale 1ns/10ps
`default_nettype none
module hall_readout
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic select_b,
   input wire logic serial_clk,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   output logic first_hold,
   output logic second_track,
   output logic conv_start,
   input wire logic adc_valid,
   input wire logic signed [hall_readout_pkg::WORD_W-1:0] adc_diff,
   input wire logic [hall_readout_pkg::OTP_W-1:0] otp_bits,
   output logic otp_burn,
   output logic [hall_readout_pkg::OTP_W-1:0] otp_wdata,
   output logic [2:0] active_weight,
   output logic [5:0] active_trim
);
   import hall_readout_pkg::*;

   top_s st;
   top_s next_st;
   word_buf_if wb ();

   logic sel_s;
   logic sel_fall;
   logic sel_rise;
   logic sck_rise;
   logic sck_fall;
   logic signed [8:0] gain;
   logic signed [20:0] prod;
   logic signed [21:0] centred;
   logic [11:0] code_new;
   logic signed [19:0] delta;
   logic signed [19:0] step;
   logic signed [19:0] acc_sum;
   logic [18:0] acc_new;

   // ----------------------------------------
   // Pin edges from second and third flops
   // ----------------------------------------
   // Select kept inverted, so cleared flops read as deselected after reset
   assign sel_s = !st.sel_sync[1];
   assign sel_fall = !st.sel_sync[2] && st.sel_sync[1];
   assign sel_rise = st.sel_sync[2] && !st.sel_sync[1];
   assign sck_rise = !sel_s && !st.sck_sync[2] && st.sck_sync[1];
   assign sck_fall = !sel_s && st.sck_sync[2] && !st.sck_sync[1];

   assign serial_out = st.shift[WORD_W-1];
   assign serial_out_oe = !sel_s;
   // Cleared state code is not idle, so list the busy states
   assign first_hold = (st.fsm == S_TRACK1) || (st.fsm == S_TRACK2) ||
                       (st.fsm == S_CONVERT);
   assign second_track = (st.fsm == S_TRACK2);
   assign conv_start = st.conv_start;
   assign otp_burn = st.burn_pulse;
   assign otp_wdata = st.burn_data;
   assign active_weight = st.weight;
   assign active_trim = st.trim;

   assign wb.wr_data = st.code;
   assign wb.wr_valid = st.pending;
   assign wb.rd_ready = sel_fall;

   word_buf u_buf
   (
      .sys_clk (sys_clk),
      .rst_b (rst_b),
      .bus (wb.store)
   );

   // ----------------------------------------
   // Gain trim and offset binary code
   // ----------------------------------------
   always_comb
   begin
      gain = signed'({1'b0, GAIN_BASE + {2'h0, st.trim}});
      prod = adc_diff * gain;
      centred = 22'(prod >>> FRAC_W) + signed'({10'h000, CODE_MID});
      if (centred < 0)
      begin
         code_new = 12'h000;
      end
      else if (centred > signed'({10'h000, CODE_MAX}))
      begin
         code_new = CODE_MAX;
      end
      else
      begin
         code_new = centred[11:0];
      end
   end

   // ----------------------------------------
   // Exponential average in 12.7 fixed point
   // ----------------------------------------
   always_comb
   begin
      delta = signed'({1'b0, code_new, 7'h00}) - signed'({1'b0, st.acc});
      step = delta >>> st.weight;
      acc_sum = signed'({1'b0, st.acc}) + step;
      if (acc_sum < 0)
      begin
         acc_new = '0;
      end
      else if (acc_sum > signed'({1'b0, CODE_MAX, 7'h7f}))
      begin
         acc_new = {CODE_MAX, 7'h7f};
      end
      else
      begin
         acc_new = acc_sum[18:0];
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.sel_sync = {st.sel_sync[1:0], !select_b};
      next_st.sck_sync = {st.sck_sync[1:0], serial_clk};
      next_st.din_sync = {st.din_sync[0], serial_in};
      next_st.conv_start = 1'b0;
      next_st.burn_pulse = 1'b0;

      // Settings reload once after reset, from nonvolatile bits
      if (!st.booted)
      begin
         next_st.booted = 1'b1;
         next_st.weight = otp_bits[8:6];
         next_st.trim = otp_bits[5:0];
      end

      // Acquisition runs off sys_clk only, serial clock not needed
      next_st.cnt = st.cnt + 12'h001;
      case (st.fsm)
         S_IDLE:
         begin
            next_st.cnt = 12'h000;
         end
         S_TRACK1:
         begin
            if (st.cnt == TRACK2_CNT - 12'h001)
            begin
               next_st.fsm = S_TRACK2;
            end
         end
         S_TRACK2:
         begin
            if (st.cnt == HOLD2_CNT - 12'h001)
            begin
               next_st.fsm = S_CONVERT;
               next_st.conv_start = 1'b1;
            end
         end
         S_CONVERT:
         begin
            next_st.cnt = st.cnt;
            if (adc_valid)
            begin
               next_st.fsm = S_IDLE;
               next_st.acc = acc_new;
               next_st.code = acc_new[18:7];
               next_st.pending = 1'b1;
            end
         end
         default:
         begin
            next_st.fsm = S_IDLE;
         end
      endcase
      if (st.pending && wb.wr_ready)
      begin
         next_st.pending = (st.fsm == S_CONVERT) && adc_valid;
      end

      // Each select fall restarts acquisition and loads the shifter if a word is buffered
      if (sel_fall)
      begin
         next_st.fsm = S_TRACK1;
         next_st.conv_start = 1'b0;
         next_st.cnt = 12'h000;
         next_st.nbits = 5'h00;
         if (wb.rd_valid)
         begin
            next_st.shift = wb.rd_data;
         end
         if (st.burn_armed)
         begin
            next_st.burn_pulse = 1'b1;
            next_st.burn_data = st.burn_val | otp_bits;
            next_st.burn_armed = 1'b0;
         end
      end
      else if (sck_fall)
      begin
         next_st.shift = {st.shift[10:0], 1'b0};
      end

      if (sck_rise)
      begin
         next_st.cmd = {st.cmd[14:0], st.din_sync[1]};
         if (st.nbits != CMD_CAP)
         begin
            next_st.nbits = st.nbits + 5'h01;
         end
      end

      // A frame of exactly sixteen bits with the right framing is a write
      if (sel_rise && st.nbits == CMD_LEN &&
          st.cmd[CMD_BITS-1:CMD_LEAD_POS] == CMD_LEAD &&
          st.cmd[CMD_TRIM_POS-1:CMD_PAD_POS] == CMD_PAD)
      begin
         next_st.weight = st.cmd[CMD_WEIGHT_POS+2:CMD_WEIGHT_POS];
         next_st.trim = st.cmd[CMD_TRIM_POS+5:CMD_TRIM_POS];
         if (st.cmd[CMD_BURN_POS])
         begin
            next_st.burn_armed = 1'b1;
            next_st.burn_val = st.cmd[CMD_WEIGHT_POS+2:CMD_TRIM_POS];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence fall_seen;
      sel_fall;
   endsequence

   chk_first_hold_soon: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fall_seen |=> first_hold) else $error("first sample not held after fall");
   chk_second_track_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(second_track) |-> st.cnt == TRACK2_CNT) else $error("second track at wrong time");
   chk_second_hold_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(conv_start) |-> st.cnt == HOLD2_CNT && st.fsm == S_CONVERT)
      else $error("second hold at wrong time");
   chk_load_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
      fall_seen ##0 wb.rd_valid |=> st.shift == $past(wb.rd_data))
      else $error("result not loaded at select fall");
   chk_out_high_z: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sel_s |-> !serial_out_oe) else $error("output driven while deselected");
   chk_ignore_deselected: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sel_s && !sel_fall && !st.sel_sync[2] |=> $stable(st.shift) && $stable(st.cmd))
      else $error("serial activity seen while deselected");
   chk_shift_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sck_fall && !sel_fall |=> st.shift == {$past(st.shift[10:0]), 1'b0})
      else $error("shift not msb first");
   chk_burn_after_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
      otp_burn |-> $past(sel_fall) && $past(st.burn_armed))
      else $error("burn pulse without arming fall");
   chk_filter_bypass: assert property (@(posedge sys_clk) disable iff (!rst_b)
      st.fsm == S_CONVERT && adc_valid && st.weight == 3'h0 |=> st.code == $past(code_new))
      else $error("weight one does not pass sample");

endmodule
`default_nettype wire

/* File: serial_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Serial link master
// ----------------------------------------
module serial_master
(
   input wire logic sys_clk,
   output logic select_b,
   output logic serial_clk,
   output logic serial_in,
   input wire logic serial_out
);
   initial
   begin
      select_b = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end

   // Clock stands still before and after each xfer frame
   task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge sys_clk);
      select_b <= 1'b0;
      repeat (8) @(posedge sys_clk);
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in <= tx[i];
         repeat (4) @(posedge sys_clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         rx = {rx[14:0], serial_out};
         serial_clk <= 1'b0;
      end
      repeat (4) @(posedge sys_clk);
      select_b <= 1'b1;
      serial_in <= 1'b0;
      // Gap of 4000 cycles lets the conversion started 96 us after the fall finish before the next fall
      repeat (4000) @(posedge sys_clk);
   endtask

   // Bits clocked with select high; the device must not react
   task automatic stray(input logic [15:0] tx);
      for (int i = 15; i >= 0; i--)
      begin
         @(posedge sys_clk);
         serial_in <= tx[i];
         repeat (4) @(posedge sys_clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         serial_clk <= 1'b0;
      end
      @(posedge sys_clk);
      serial_in <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import hall_readout_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic select_b, serial_clk, serial_in, serial_out, serial_out_oe;
   logic first_hold, second_track, conv_start, otp_burn;
   logic adc_valid = 1'b0;
   logic signed [11:0] adc_diff = 12'h000;
   logic [8:0] otp_bits = 9'h000;
   logic [8:0] otp_wdata;
   logic [2:0] active_weight;
   logic [5:0] active_trim;
   logic [2:0] vcnt = 3'h0;
   logic track_q = 1'b0;
   logic [12:0] since = 13'h0000;
   logic [11:0] exp_q = 12'h000;
   int err_total = 0;
   int tests_run = 0;
   int burns = 0;
   int cyc = 0;
   int acc_m = 0;

   always #12.5 sys_clk = ~sys_clk;

   serial_master m (.sys_clk(sys_clk), .select_b(select_b), .serial_clk(serial_clk),
      .serial_in(serial_in), .serial_out(serial_out));

   hall_readout DUT (.sys_clk(sys_clk), .rst_b(rst_b), .select_b(select_b),
      .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .first_hold(first_hold), .second_track(second_track),
      .conv_start(conv_start), .adc_valid(adc_valid), .adc_diff(adc_diff),
      .otp_bits(otp_bits), .otp_burn(otp_burn), .otp_wdata(otp_wdata),
      .active_weight(active_weight), .active_trim(active_trim));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Converter, one-time memory, watchdog
   // ----------------------------------------
   always @(posedge sys_clk)
   begin
      adc_valid <= 1'b0;
      if (conv_start === 1'b1)
         vcnt <= 3'h5;
      else if (vcnt != 3'h0)
      begin
         vcnt <= vcnt - 3'h1;
         adc_valid <= (vcnt == 3'h1);
      end
      since <= (first_hold === 1'b1) ? since + 13'h0001 : 13'h0000;
      if (conv_start === 1'b1)
         check("conv time", 16'(since > 13'd3825 && since < 13'd3845), 16'h0001);
      track_q <= second_track;
      if (second_track === 1'b1 && track_q !== 1'b1)
         check("track time", 16'(since > 13'd1275 && since < 13'd1285), 16'h0001);
      if (serial_clk === 1'b1)
         check("oe follows select", 16'(serial_out_oe), 16'(!select_b));
      if (otp_burn === 1'b1)
      begin
         // Burned ones cannot clear
         otp_bits <= otp_bits | otp_wdata;
         burns <= burns + 1;
      end
      cyc <= cyc + 1;
      if (cyc > 100000)
      begin
         err_total++;
         complete_run();
      end
   end

   function automatic logic [11:0] code_of(input int diff, input int trim);
      int v;
      v = 2048 + (96 + trim) * diff / 128;
      if (v > 4095)
         v = 4095;
      if (v < 0)
         v = 0;
      return 12'(v);
   endfunction

   function automatic logic [15:0] cmd(input logic [2:0] w, input logic [5:0] t, input logic b);
      return {2'h2, w, t, 4'h0, b};
   endfunction

   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge sys_clk);
      acc_m = 0;
      exp_q = 12'h000;
   endtask

   // Word seen now belongs to the previous acquisition
   task automatic go(input string name, input int n, input logic [15:0] tx, input int diff,
                     input int w, input int t);
      logic [15:0] rx;
      logic [15:0] al;
      adc_diff <= 12'(diff);
      m.xfer(n, tx, rx);
      al = rx << (16 - n);
      check(name, {4'h0, al[15:4]}, {4'h0, exp_q});
      check("idle oe", 16'(serial_out_oe), 16'h0000);
      acc_m = acc_m + ((int'(code_of(diff, t)) * 128 - acc_m) >>> w);
      exp_q = 12'(acc_m >>> 7);
      $display("test %s done", name);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      do_reset();
      check("oe after reset", 16'(serial_out_oe), 16'h0000);
      go("reset word", 12, 16'h0000, 128, 0, 0);
      go("zero trim", 12, 16'h0000, -128, 0, 0);
      go("preview", 16, cmd(3'h0, 6'h20, 1'b0), 128, 0, 32);
      check("preview trim", 16'(active_trim), 16'h0020);
      m.stray(cmd(3'h7, 6'h15, 1'b1));
      check("stray ignored", 16'({active_weight, active_trim}), 16'h0020);
      go("full gain", 16, cmd(3'h0, 6'h3f, 1'b0), 2047, 0, 63);
      check("full trim", 16'(active_trim), 16'h003f);
      go("burn cmd", 16, cmd(3'h1, 6'h0c, 1'b1), 128, 1, 12);
      check("no burn yet", 16'(burns), 16'h0000);
      check("burn weight", 16'(active_weight), 16'h0001);
      go("after burn", 16, 16'h0000, 128, 1, 12);
      check("burn count", 16'(burns), 16'h0001);
      check("burn data", 16'(otp_wdata), 16'h004c);
      do_reset();
      check("reload", 16'({active_weight, active_trim}), 16'h004c);
      go("filter zero", 12, 16'h0000, 128, 1, 12);
      go("filter one", 12, 16'h0000, 128, 1, 12);
      go("filter two", 12, 16'h0000, 128, 1, 12);
      complete_run();
   end
endmodule
`default_nettype wire
